// ---- logic/charger_cmd_pkg.sv ----
// Constants for the charger configuration command block.
//
// Functional notes
// - Maintain timer from byte 0 bits 5:4.
// - Fast-charge timer from byte 0 bits 3:2.
// - Precharge timer from byte 0 bits 1:0.
// - Precharge threshold 2.1 V plus 150 mV steps.
// - Done current ratio from byte 1 bits 1:0.
// - Byte 2 bit 7 enables auto-stop.
// - Byte 2 bit 6 enables auto-restart.
// - Recharge threshold is regulation minus offset.
// - Regulation voltage 4.05 V plus 50 mV steps.
// - System minimum 3.6 V plus 100 mV steps.
// - Writes echo opcode; read returns four bytes.
// - Four 8-bit zone boundaries compared with thermistor.
// - Protected update needs password 0x1E7A, high first.
// - Wrong password under protection reports error 0x11.
// - Limits read returns four boundaries, no password.
// - Bit 7 enables zone charging, room excepted.
// - Zone bits 4:3 lower regulation by offset.
// - Zone bits 2:0 scale fast-charge current.
// - Five zone bytes then password; reject wrong.
// - Settings return to defaults on charger insertion.
package charger_cmd_pkg;
   // ----------------------------------------------------------
   // Opcodes, answers and password.
   // ----------------------------------------------------------
   localparam logic [7:0]  OP_CFG_WR    = 8'h14;
   localparam logic [7:0]  OP_CFG_RD    = 8'h15;
   localparam logic [7:0]  OP_LIM_WR    = 8'h16;
   localparam logic [7:0]  OP_LIM_RD    = 8'h17;
   localparam logic [7:0]  OP_ZONE_WR   = 8'h18;
   localparam logic [7:0]  RESP_UNKNOWN = 8'h00;
   localparam logic [15:0] PASSWORD     = 16'h1E7A;
   localparam logic [7:0]  ERR_BAD_PW   = 8'h11;
   // ----------------------------------------------------------
   // Register word indices; byte address is four times these.
   // ----------------------------------------------------------
   localparam logic [3:0]  IDX_OPCODE   = 4'h0;
   localparam logic [3:0]  IDX_PAYLOAD  = 4'h1;
   localparam logic [3:0]  IDX_RESPONSE = 4'h8;
   localparam logic [3:0]  IDX_DEVDATA  = 4'h9;
   localparam logic [3:0]  IDX_DEVLAST  = 4'hC;
   localparam logic [3:0]  IDX_STATUS   = 4'hD;
   localparam logic [3:0]  IDX_CONTROL  = 4'hE;
   // ----------------------------------------------------------
   // Stored-byte masks, so reserved bits read as zero.
   // ----------------------------------------------------------
   localparam logic [7:0]  CFG_MASK [4] = '{8'h3F, 8'h7F, 8'hFF, 8'h07};
   localparam logic [7:0]  ZONE_MASK    = 8'h9F;
   localparam logic [7:0]  ROOM_MASK    = 8'h1F;
   localparam int          ROOM_ZONE    = 2;
   localparam logic [3:0]  BR_MAX_CODE  = 4'hB;
   // ----------------------------------------------------------
   // Defaults restored by reset and by charger insertion.
   // ----------------------------------------------------------
   localparam logic [7:0]  CFG_DEF  [4] = '{8'h25, 8'h25, 8'hC3, 8'h02};
   localparam logic [7:0]  LIM_DEF  [4] = '{8'hC0, 8'hA0, 8'h50, 8'h30};
   localparam logic [7:0]  ZONE_DEF [5] = '{8'h02, 8'h9D, 8'h1F, 8'h9D, 8'h02};
   // ----------------------------------------------------------
   // Decode tables: minutes, percent and millivolts.
   // ----------------------------------------------------------
   localparam logic [9:0]  MAINT_MIN [4] = '{10'h000, 10'h00F, 10'h01E, 10'h03C};
   localparam logic [9:0]  FAST_MIN  [4] = '{10'h04B, 10'h096, 10'h12C, 10'h258};
   localparam logic [9:0]  PRE_MIN   [4] = '{10'h01E, 10'h03C, 10'h078, 10'h0F0};
   localparam logic [6:0]  RATIO_PCT [4] = '{7'h05, 7'h0A, 7'h14, 7'h1E};
   localparam logic [12:0] RECHG_MV  [4] = '{13'h0046, 13'h0078, 13'h00AA, 13'h00DC};
   localparam logic [12:0] ZONE_V_MV [4] = '{13'h0096, 13'h0064, 13'h0032, 13'h0000};
   localparam logic [6:0]  ZONE_I_PCT [8] =
      '{7'h14, 7'h1E, 7'h28, 7'h32, 7'h3C, 7'h46, 7'h50, 7'h64};
   localparam logic [12:0] VPRE_BASE = 13'h0834;
   localparam logic [12:0] VPRE_STEP = 13'h0096;
   localparam logic [12:0] BREG_BASE = 13'h0FD2;
   localparam logic [12:0] BREG_STEP = 13'h0032;
   localparam logic [12:0] SMIN_BASE = 13'h0E10;
   localparam logic [12:0] SMIN_STEP = 13'h0064;
endpackage

// ---- logic/charger_config_commands.sv ----
// Charger configuration command interpreter behind an Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
module charger_config_commands
   import charger_cmd_pkg::*;
(
   input  wire logic        clk,                  // 25 MHz clock.
   input  wire logic        rst,                  // Synchronous reset.
   input  wire logic [5:0]  avs_address,          // Byte address.
   input  wire logic        avs_read,             // Read request.
   input  wire logic        avs_write,            // Write request.
   input  wire logic [31:0] avs_writedata,        // Write data.
   input  wire logic [3:0]  avs_byteenable,       // Byte lanes.
   output logic      [31:0] avs_readdata,         // Read data.
   output logic             avs_waitrequest,      // Stall.
   input  wire logic        inputValidInterrupt,  // Charger inserted.
   input  wire logic [7:0]  thermistorPin,        // Thermistor code.
   output logic [9:0]       maintainChargeTimer_r,       // Minutes.
   output logic [9:0]       fastChargeTimer_r,           // Minutes.
   output logic [9:0]       prechargeTimer_r,            // Minutes.
   output logic [12:0]      prechargeVoltageThreshold_r, // mV.
   output logic [6:0]       prechargeCurrentRatio_r,     // Percent.
   output logic [6:0]       doneCurrentRatio_r,          // Percent.
   output logic             autoStopEnable_r,            // Auto-stop.
   output logic             autoRestartEnable_r,         // Auto-restart.
   output logic [12:0]      rechargeThreshold_r,         // mV.
   output logic [12:0]      batteryRegulationVoltage_r,  // mV.
   output logic [12:0]      systemMinimumVoltage_r,      // mV.
   output logic [3:0][7:0]  zoneBoundary_r,              // Cold..hot.
   output logic [4:0]       zoneChargeEnable_r,          // Per zone.
   output logic [4:0][12:0] zoneRegulationVoltage_r,     // mV.
   output logic [4:0][6:0]  zoneCurrentScale_r,          // Percent.
   output logic [4:0]       activeZone_r,                // One-hot.
   output logic [7:0]       systemErrorCode_r            // Error.
);

   // ----------------------------------------------------------
   // Storage.
   // ----------------------------------------------------------
   logic [7:0]  payload_r [7];
   logic [7:0]  cfg_r     [4];
   logic [7:0]  zone_r    [5];
   logic [7:0]  devData_r [4];
   logic [7:0]  opcode_r;
   logic [7:0]  response_r;
   logic        writeProtect_r;
   logic        wait_r;
   logic [31:0] readData_r;

   // ----------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------
   wire logic [3:0]  idx;
   wire logic        wrAcc;
   wire logic        cmdGo;
   wire logic [7:0]  cmdOp;
   wire logic [15:0] limPw;
   wire logic [15:0] zonePw;
   wire logic        limPwOk;
   wire logic        zonePwOk;
   wire logic        limWr;
   wire logic        zoneWr;
   wire logic        cfgWr;
   wire logic        badPw;
   wire logic        errClr;
   wire logic        isKnown;
   wire logic        isPay;
   wire logic        isDev;
   wire logic [7:0]  rdByte;

   // The request is taken on the edge where the stall is low.
   assign idx   = avs_address[5:2];
   assign wrAcc = avs_write & ~wait_r & avs_byteenable[0];
   assign cmdGo = wrAcc && (idx == IDX_OPCODE);
   assign cmdOp = avs_writedata[7:0];

   // Passwords arrive high byte first after the data bytes.
   assign limPw    = {payload_r[4], payload_r[5]};
   assign zonePw   = {payload_r[5], payload_r[6]};
   assign limPwOk  = ~writeProtect_r | (limPw == PASSWORD);
   assign zonePwOk = ~writeProtect_r | (zonePw == PASSWORD);

   // Command strobes; a rejected write stores no limit or zone bytes.
   assign cfgWr  = cmdGo && (cmdOp == OP_CFG_WR);
   assign limWr  = cmdGo && (cmdOp == OP_LIM_WR) && limPwOk;
   assign zoneWr = cmdGo && (cmdOp == OP_ZONE_WR) && zonePwOk;
   assign badPw  = cmdGo && (((cmdOp == OP_LIM_WR) && !limPwOk) ||
                             ((cmdOp == OP_ZONE_WR) && !zonePwOk));
   assign errClr = wrAcc && (idx == IDX_STATUS);
   assign isKnown = (cmdOp >= OP_CFG_WR) && (cmdOp <= OP_ZONE_WR);

   // Read multiplexer; unmapped words read as zero.
   assign isPay = (idx >= IDX_PAYLOAD) && (idx < IDX_RESPONSE);
   assign isDev = (idx >= IDX_DEVDATA) && (idx <= IDX_DEVLAST);
   assign rdByte =
      (idx == IDX_OPCODE)   ? opcode_r :
      isPay                 ? payload_r[3'(idx - IDX_PAYLOAD)] :
      (idx == IDX_RESPONSE) ? response_r :
      isDev                 ? devData_r[2'(idx - IDX_DEVDATA)] :
      (idx == IDX_STATUS)   ? systemErrorCode_r :
      (idx == IDX_CONTROL)  ? {7'h00, writeProtect_r} :
                              8'h00;

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = readData_r;

   // Stall for one cycle on every access, then answer.
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r     <= 1'b1;
         readData_r <= 32'h0000_0000;
      end else begin
         wait_r     <= ~((avs_read | avs_write) & wait_r);
         readData_r <= {24'h00_0000, rdByte};
      end
   end

   // ----------------------------------------------------------
   // Mailbox registers written by the host.
   // ----------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < 7; k++) begin : g_payload
         // Each payload byte is a plain read/write register.
         always_ff @(posedge clk) begin
            if (rst) begin
               payload_r[k] <= 8'h00;
            end else if (wrAcc && (idx == IDX_PAYLOAD + 4'(k))) begin
               payload_r[k] <= avs_writedata[7:0];
            end
         end
      end
   endgenerate

   // Opcode, protection switch and error code.
   always_ff @(posedge clk) begin
      if (rst) begin
         opcode_r          <= 8'h00;
         writeProtect_r    <= 1'b0;
         systemErrorCode_r <= 8'h00;
      end else begin
         if (cmdGo) begin
            opcode_r <= cmdOp;
         end
         if (wrAcc && (idx == IDX_CONTROL)) begin
            writeProtect_r <= avs_writedata[0];
         end
         if (badPw) begin
            systemErrorCode_r <= ERR_BAD_PW;
         end else if (errClr) begin
            systemErrorCode_r <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------
   // Command execution and answer bytes.
   // ----------------------------------------------------------
   generate
      for (k = 0; k < 4; k++) begin : g_cfg
         // Configuration byte and limit byte k, plus answer byte.
         always_ff @(posedge clk) begin
            if (rst || inputValidInterrupt) begin
               cfg_r[k]          <= CFG_DEF[k];
               zoneBoundary_r[k] <= LIM_DEF[k];
            end else begin
               if (cfgWr) begin
                  cfg_r[k] <= payload_r[k] & CFG_MASK[k];
               end
               if (limWr) begin
                  zoneBoundary_r[k] <= payload_r[k];
               end
            end
            if (rst) begin
               devData_r[k] <= 8'h00;
            end else if (cmdGo) begin
               devData_r[k] <= (cmdOp == OP_CFG_RD) ? cfg_r[k] :
                               (cmdOp == OP_LIM_RD) ? zoneBoundary_r[k] :
                                                      8'h00;
            end
         end
      end
   endgenerate

   // Every known opcode is echoed; others answer zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         response_r <= 8'h00;
      end else if (cmdGo) begin
         response_r <= isKnown ? cmdOp : RESP_UNKNOWN;
      end
   end

   // ----------------------------------------------------------
   // Charger setting decode.
   // ----------------------------------------------------------
   wire logic [3:0]  bregCode;
   wire logic [12:0] bregMv;

   // Codes above the last listed step hold at the top value.
   assign bregCode = (cfg_r[2][3:0] > BR_MAX_CODE) ? BR_MAX_CODE : cfg_r[2][3:0];
   assign bregMv   = BREG_BASE + BREG_STEP * {9'h000, bregCode};

   // Decoded settings are refreshed from storage every cycle.
   always_ff @(posedge clk) begin
      maintainChargeTimer_r       <= MAINT_MIN[cfg_r[0][5:4]];
      fastChargeTimer_r           <= FAST_MIN[cfg_r[0][3:2]];
      prechargeTimer_r            <= PRE_MIN[cfg_r[0][1:0]];
      prechargeVoltageThreshold_r <= VPRE_BASE +
                                     VPRE_STEP * {10'h000, cfg_r[1][6:4]};
      prechargeCurrentRatio_r     <= RATIO_PCT[cfg_r[1][3:2]];
      doneCurrentRatio_r          <= RATIO_PCT[cfg_r[1][1:0]];
      autoStopEnable_r            <= cfg_r[2][7];
      autoRestartEnable_r         <= cfg_r[2][6];
      rechargeThreshold_r         <= bregMv - RECHG_MV[cfg_r[2][5:4]];
      batteryRegulationVoltage_r  <= bregMv;
      systemMinimumVoltage_r      <= SMIN_BASE +
                                     SMIN_STEP * {10'h000, cfg_r[3][2:0]};
   end

   // ----------------------------------------------------------
   // Per-zone profiles, cold, cool, room, warm, hot.
   // ----------------------------------------------------------
   generate
      for (k = 0; k < 5; k++) begin : g_zone
         // The room byte carries no enable bit.
         localparam logic [7:0] ZMASK = (k == ROOM_ZONE) ? ROOM_MASK : ZONE_MASK;
         always_ff @(posedge clk) begin
            if (rst || inputValidInterrupt) begin
               zone_r[k] <= ZONE_DEF[k] & ZMASK;
            end else if (zoneWr) begin
               zone_r[k] <= payload_r[k] & ZMASK;
            end
            zoneChargeEnable_r[k]      <= (k == ROOM_ZONE) | zone_r[k][7];
            zoneRegulationVoltage_r[k] <= bregMv - ZONE_V_MV[zone_r[k][4:3]];
            zoneCurrentScale_r[k]      <= ZONE_I_PCT[zone_r[k][2:0]];
         end
      end
   endgenerate

   // ----------------------------------------------------------
   // Thermistor zone selection.
   // ----------------------------------------------------------
   wire logic isCold;
   wire logic isCool;
   wire logic isWarm;
   wire logic isHot;

   // A high pin voltage means a cold battery.
   assign isCold = thermistorPin >= zoneBoundary_r[0];
   assign isCool = thermistorPin >= zoneBoundary_r[1];
   assign isHot  = thermistorPin <= zoneBoundary_r[3];
   assign isWarm = thermistorPin <= zoneBoundary_r[2];

   // Colder and hotter matches take precedence.
   always_ff @(posedge clk) begin
      if (rst) begin
         activeZone_r <= 5'h04;
      end else begin
         activeZone_r[0] <= isCold;
         activeZone_r[1] <= ~isCold & isCool;
         activeZone_r[4] <= ~isCold & ~isCool & isHot;
         activeZone_r[3] <= ~isCold & ~isCool & ~isHot & isWarm;
         activeZone_r[2] <= ~isCold & ~isCool & ~isHot & ~isWarm;
      end
   end

   // ----------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_maint_timer: assert property (
      $past(cfg_r[0][5:4]) == 2'h3 |-> maintainChargeTimer_r == 10'h03C)
      else $error("maintain timer decode wrong");
   a_fast_timer: assert property (
      $past(cfg_r[0][3:2]) == 2'h0 |-> fastChargeTimer_r == 10'h04B)
      else $error("fast timer decode wrong");
   a_pre_timer: assert property (
      $past(cfg_r[0][1:0]) == 2'h3 |-> prechargeTimer_r == 10'h0F0)
      else $error("precharge timer decode wrong");
   a_pre_volt: assert property (
      $past(cfg_r[1][6:4]) == 3'h7 |-> prechargeVoltageThreshold_r == 13'h0C4E)
      else $error("precharge voltage wrong");
   a_pre_ratio: assert property (
      $past(cfg_r[1][3:2]) == 2'h0 |-> prechargeCurrentRatio_r == 7'h05)
      else $error("precharge ratio wrong");
   a_done_ratio: assert property (
      $past(cfg_r[1][1:0]) == 2'h3 |-> doneCurrentRatio_r == 7'h1E)
      else $error("done ratio wrong");
   a_auto_stop: assert property (
      autoStopEnable_r == $past(cfg_r[2][7]))
      else $error("auto-stop bit not applied");
   a_auto_restart: assert property (
      autoRestartEnable_r == $past(cfg_r[2][6]))
      else $error("auto-restart bit not applied");
   a_recharge_gap: assert property (
      $past(cfg_r[2][5:4]) == 2'h3 |->
         rechargeThreshold_r + 13'h00DC == batteryRegulationVoltage_r)
      else $error("recharge offset wrong");
   a_bat_reg: assert property (
      $past(cfg_r[2][3:0]) >= 4'hB |-> batteryRegulationVoltage_r == 13'h11F8)
      else $error("regulation voltage wrong");
   a_sys_min: assert property (
      $past(cfg_r[3][2:0]) == 3'h7 |-> systemMinimumVoltage_r == 13'h10CC)
      else $error("system minimum wrong");
   a_write_echo: assert property (
      cfgWr |=> response_r == OP_CFG_WR)
      else $error("write not echoed");
   a_cfg_read: assert property (
      cmdGo && cmdOp == OP_CFG_RD |=> devData_r[3] == $past(cfg_r[3]))
      else $error("config read data wrong");
   a_cold_zone: assert property (
      $past(thermistorPin) >= $past(zoneBoundary_r[0]) |-> activeZone_r == 5'h01)
      else $error("cold zone not selected");
   a_pw_accept: assert property (
      cmdGo && cmdOp == OP_LIM_WR && limPw == PASSWORD && !inputValidInterrupt
         |=> zoneBoundary_r[3] == $past(payload_r[3]))
      else $error("good password refused");
   a_bad_pw_err: assert property (
      badPw |=> systemErrorCode_r == ERR_BAD_PW)
      else $error("bad password not flagged");
   a_lim_read: assert property (
      cmdGo && cmdOp == OP_LIM_RD |=> devData_r[1] == $past(zoneBoundary_r[1]))
      else $error("limit read data wrong");
   a_room_enable: assert property (
      zoneChargeEnable_r[2] && zoneChargeEnable_r[0] == $past(zone_r[0][7]))
      else $error("zone enable wrong");
   a_zone_volt: assert property (
      $past(zone_r[1][4:3]) == 2'h0 |->
         zoneRegulationVoltage_r[1] + 13'h0096 == batteryRegulationVoltage_r)
      else $error("zone voltage wrong");
   a_zone_curr: assert property (
      $past(zone_r[4][2:0]) == 3'h7 |-> zoneCurrentScale_r[4] == 7'h64)
      else $error("zone current wrong");
   a_zone_reject: assert property (
      badPw && cmdOp == OP_ZONE_WR && !inputValidInterrupt
         |=> zone_r[3] == $past(zone_r[3]))
      else $error("zone write not rejected");
   a_insert_dflt: assert property (
      inputValidInterrupt |=> cfg_r[2] == CFG_DEF[2] && zone_r[1] == ZONE_DEF[1])
      else $error("insertion default missing");
   a_lim_keep: assert property (
      badPw && !inputValidInterrupt |=> zoneBoundary_r[0] == $past(zoneBoundary_r[0]))
      else $error("rejected write changed limits");

   // Handshake, error-clear, answer, stored-write and zone-choice checks.
   a_wait_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_err_clear: assert property (
      errClr |=> systemErrorCode_r == 8'h00)
      else $error("status write did not clear");
   a_unknown_op: assert property (
      cmdGo && !isKnown |=> response_r == RESP_UNKNOWN)
      else $error("unknown opcode answer wrong");
   a_lim_echo: assert property (
      cmdGo && cmdOp == OP_LIM_WR |=> response_r == OP_LIM_WR)
      else $error("limit write not echoed");
   a_lim_store: assert property (
      limWr && !inputValidInterrupt |=> zoneBoundary_r[2] == $past(payload_r[2]))
      else $error("limit write not stored");
   a_zone_store: assert property (
      zoneWr && !inputValidInterrupt |=> zone_r[0] == ($past(payload_r[0]) & ZONE_MASK))
      else $error("zone write not stored");
   a_one_zone: assert property (
      $onehot(activeZone_r))
      else $error("zone choice not one-hot");
   a_hot_zone: assert property (
      !$past(rst) && $past(thermistorPin) < $past(zoneBoundary_r[0]) &&
         $past(thermistorPin) < $past(zoneBoundary_r[1]) &&
         $past(thermistorPin) <= $past(zoneBoundary_r[3]) |-> activeZone_r == 5'h10)
      else $error("hot zone not selected");

endmodule // charger_config_commands
`default_nettype wire

// ---- tb/charger_config_commands_tb.sv ----
// Self-checking bench for the charger configuration command block.
`timescale 1ns/100ps
`default_nettype none
module charger_config_commands_tb;
   import charger_cmd_pkg::*;
   logic clk, rst, rd, wr, ins, waitReq, aStop, aRe;
   logic [5:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [7:0] therm, err, op;
   logic [9:0] mt, ft, pt;
   logic [12:0] vpre, rech, breg, smin;
   logic [6:0] pre, done;
   logic [3:0][7:0] lim;
   logic [4:0] zen, zact;
   logic [4:0][12:0] zv;
   logic [4:0][6:0] zi;
   logic [7:0] cfg[4], lm[4], zn[5], b[$];
   int miscompares = 0, nCompared = 0;
   int mtT[4] = '{0, 15, 30, 60}, ftT[4] = '{75, 150, 300, 600};
   int ptT[4] = '{30, 60, 120, 240}, rtT[4] = '{5, 10, 20, 30};
   int rcT[4] = '{70, 120, 170, 220}, zvT[4] = '{150, 100, 50, 0};

   host_model #(.INS_WAIT(20)) u_host (.clk(clk), .adr(adr), .rd(rd), .wr(wr),
      .wdat(wdat), .ins(ins), .rdat(rdat), .waitReq(waitReq));
   charger_config_commands u_dut (.clk(clk), .rst(rst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'h1),
      .avs_readdata(rdat), .avs_waitrequest(waitReq), .inputValidInterrupt(ins),
      .thermistorPin(therm), .maintainChargeTimer_r(mt), .fastChargeTimer_r(ft),
      .prechargeTimer_r(pt), .prechargeVoltageThreshold_r(vpre),
      .prechargeCurrentRatio_r(pre), .doneCurrentRatio_r(done),
      .autoStopEnable_r(aStop), .autoRestartEnable_r(aRe), .rechargeThreshold_r(rech),
      .batteryRegulationVoltage_r(breg), .systemMinimumVoltage_r(smin),
      .zoneBoundary_r(lim), .zoneChargeEnable_r(zen), .zoneRegulationVoltage_r(zv),
      .zoneCurrentScale_r(zi), .activeZone_r(zact), .systemErrorCode_r(err));

   // Clock at 25 MHz.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Closing report and verdict.
   task automatic printVerdict();
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      nCompared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rdb(input logic [5:0] a, input logic [7:0] e);
      u_host.acc(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask

   // Regulation voltage in millivolts; codes above eleven clamp.
   function automatic int brMv();
      return 4050 + 50 * ((cfg[2][3:0] > 4'hB) ? 11 : int'(cfg[2][3:0]));
   endfunction

   task automatic chkCfg();
      chk(mt, mtT[cfg[0][5:4]]);
      chk(ft, ftT[cfg[0][3:2]]);
      chk(pt, ptT[cfg[0][1:0]]);
      chk(vpre, 2100 + 150 * cfg[1][6:4]);
      chk(pre, rtT[cfg[1][3:2]]);
      chk(done, rtT[cfg[1][1:0]]);
      chk(aStop, cfg[2][7]);
      chk(aRe, cfg[2][6]);
      chk(rech, brMv() - rcT[cfg[2][5:4]]);
      chk(breg, brMv());
      chk(smin, 3600 + 100 * cfg[3][2:0]);
   endtask

   task automatic chkZone();
      int z;
      z = (therm >= lm[0]) ? 0 : (therm >= lm[1]) ? 1 : (therm <= lm[3]) ? 4 :
          (therm <= lm[2]) ? 3 : 2;
      for (int i = 0; i < 5; i++) begin
         chk(zen[i], (i == 2) ? 1'b1 : zn[i][7]);
         chk(zv[i], brMv() - zvT[zn[i][4:3]]);
         chk(zi[i], (zn[i][2:0] == 3'h7) ? 100 : 20 + 10 * zn[i][2:0]);
      end
      for (int i = 0; i < 4; i++) chk(lim[i], lm[i]);
      chk(zact, 32'h1 << z);
   endtask

   // Watchdog sized well past the expected run of under a thousand cycles.
   initial begin
      #2000000;
      miscompares++;
      printVerdict();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      therm = 8'h00;
      cfg = CFG_DEF;
      lm = LIM_DEF;
      zn = ZONE_DEF;
      void'($urandom(77));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chkCfg();
      chkZone();
      for (int k = 0; k < 10; k++) begin
         b = {};
         repeat (4) b.push_back((k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom));
         therm <= 8'($urandom);
         u_host.send(8'h14, b, 16'h0000);
         foreach (b[i]) cfg[i] = b[i] & CFG_MASK[i];
         rdb(6'h20, 8'h14);
         b = {};
         u_host.send(8'h15, b, 16'h0000);
         rdb(6'h20, 8'h15);
         for (int i = 0; i < 4; i++) rdb(6'(36 + 4 * i), cfg[i]);
         chkCfg();
      end
      u_host.send(8'h3A, b, 16'h0000);
      rdb(6'h20, RESP_UNKNOWN);
      $display("config test done");
      for (int k = 0; k < 6; k++) begin
         op = (k < 3) ? 8'h16 : 8'h18;
         therm <= 8'($urandom);
         u_host.acc(1'b1, 6'h34, 8'h00, q);
         u_host.acc(1'b1, 6'h38, {7'h00, k % 3 != 0}, q);
         b = {};
         repeat ((k < 3) ? 4 : 5) b.push_back((k == 3) ? 8'hFF :
            8'($urandom) & ((k == 5) ? 8'hE7 : 8'hFF));
         u_host.send(op, b, (k % 3 == 1) ? 16'h7A1E : 16'h1E7A ^ (k % 3 == 0));
         rdb(6'h20, op);
         rdb(6'h34, (k % 3 == 1) ? 8'h11 : 8'h00);
         chk(err, (k % 3 == 1) ? 8'h11 : 8'h00);
         if (k % 3 != 1) begin
            foreach (b[i]) if (k < 3) lm[i] = b[i];
            else zn[i] = b[i] & ((i == ROOM_ZONE) ? ROOM_MASK : ZONE_MASK);
         end
         b = {};
         u_host.send(8'h17, b, 16'h0000);
         for (int i = 0; i < 4; i++) rdb(6'(36 + 4 * i), lm[i]);
         chkZone();
      end
      rdb(6'h3C, 8'h00);
      $display("password test done");
      u_host.insert();
      cfg = CFG_DEF;
      lm = LIM_DEF;
      zn = ZONE_DEF;
      chkCfg();
      chkZone();
      $display("insertion test done");
      printVerdict();
   end
endmodule // charger_config_commands_tb
`default_nettype wire

// ---- tb/host_model.sv ----
// Host processor model issuing mailbox commands over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module host_model #(
   parameter int INS_WAIT = 250000      // Cycles held off after insertion.
) (
   input  wire logic        clk,        // Clock.
   output logic [5:0]       adr,        // Byte address.
   output logic             rd,         // Read request.
   output logic             wr,         // Write request.
   output logic [31:0]      wdat,       // Write data.
   output logic             ins,        // Charger inserted.
   input  wire logic [31:0] rdat,       // Read data.
   input  wire logic        waitReq     // Stall.
);
   // The bus is idle from time zero.
   initial {adr, rd, wr, wdat, ins} = '0;

   // One access, held until waitrequest is seen low, then released.
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      do @(posedge clk); while (waitReq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   // Payload first and opcode last; the password trails, high byte first.
   task automatic send(input logic [7:0] op, input logic [7:0] b[$],
                       input logic [15:0] pw);
      logic [31:0] q;
      if (op == 8'h16 || op == 8'h18) begin
         b.push_back(pw[15:8]);
         b.push_back(pw[7:0]);
      end
      foreach (b[i]) acc(1'b1, 6'(4 + 4 * i), b[i], q);
      acc(1'b1, 6'h00, op, q);
   endtask

   // Insertion pulse; settings are left alone until the hold-off ends.
   task automatic insert();
      ins <= 1'b1;
      @(posedge clk);
      ins <= 1'b0;
      repeat (INS_WAIT) @(posedge clk);
   endtask
endmodule // host_model
`default_nettype wire
